// ===== bench/eqt_host.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural host controller issuing query reads and writes over apb
module eqt_host
	import eqt_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      pready,
	input  wire eqt_word_t prdata,
	input  wire logic      pslverr,
	output var  logic      psel,
	output var  logic      penable,
	output var  logic      pwrite,
	output var  eqt_addr_t paddr,
	output var  eqt_word_t pwdata
);
	////////////////////////////////////////////////////////////////////////////
	// idle bus at time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////////
	// one transfer; entered just after a rising edge, leaves one edge after
	task automatic xfer(input logic w, input eqt_addr_t a, input eqt_word_t d,
		output eqt_word_t rd, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// wait for the slave under a bound; it never stalls today
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		rd = prdata;
		er = pslverr;
		// released data no longer holds the last value
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		// a slave that never answers ends the run as a failure
		if (pready !== 1'b1)
		begin
			testbench.bad_count++;
			testbench.complete_run();
		end
		else
			@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import eqt_pkg::*;
	logic      ref_clk = 1'b0;  // 100 mhz
	logic      rst_n = 1'b0;    // async, active low
	logic      psel, penable, pwrite, pready, pslverr;
	eqt_addr_t paddr;
	eqt_word_t pwdata, prdata;
	int        bad_count = 0;
	int        checked = 0;
	eqt_word_t rd;
	int        n_tab = 0;  // bench tally of completed table reads
	logic      er;
	// table bytes from index 10Ah upward, non-mux variant
	eqt_byte_t tbl [14] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h34, 8'hE6, 8'h07,
		8'h00, 8'h00, 8'h01, 8'h33, 8'h00, 8'h18, 8'h90};

	always #5 ref_clk = ~ref_clk;

	eqt_rom u_eqt_rom (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	eqt_host u_eqt_host (.clk(ref_clk), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));

	////////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input eqt_word_t seen, input eqt_word_t exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input eqt_addr_t a, input eqt_word_t exp, input logic xer);
		u_eqt_host.xfer(1'b0, a, 32'h00000000, rd, er);
		check(rd, exp);
		check({31'h0, er}, {31'h0, xer});
		if (a >= 12'h428 && a <= 12'h45C && a[1:0] == 2'h0)
			n_tab++;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// every table location, byte low and upper bits zero
	task automatic t_table();
		for (int i = 0; i < 14; i++)
			rd_chk(12'h428 + 12'(4 * i), {24'h000000, tbl[i]}, 1'b0);
		// extension flag clear, so the host parses no further field
		rd_chk(12'h448, 32'h00000000, 1'b0);
		$display("test table done");
	endtask

	// writes to table bytes are taken without error and dropped
	task automatic t_write();
		u_eqt_host.xfer(1'b1, 12'h43C, 32'hFFFFFFFF, rd, er);
		check({31'h0, er}, 32'h00000000);
		u_eqt_host.xfer(1'b1, 12'h45C, 32'h00000000, rd, er);
		check({31'h0, er}, 32'h00000000);
		rd_chk(12'h43C, 32'h000000E6, 1'b0);
		rd_chk(12'h45C, 32'h00000090, 1'b0);
		$display("test write done");
	endtask

	// variant select flips the page read bit only
	task automatic t_mux();
		rd_chk(12'h000, 32'h00000000, 1'b0);
		u_eqt_host.xfer(1'b1, 12'h000, 32'h00000001, rd, er);
		rd_chk(12'h43C, 32'h00000066, 1'b0);
		rd_chk(12'h440, 32'h00000007, 1'b0);
		u_eqt_host.xfer(1'b1, 12'h000, 32'h00000000, rd, er);
		rd_chk(12'h43C, 32'h000000E6, 1'b0);
		$display("test mux done");
	endtask

	// unmapped and misaligned places are refused with zero data
	task automatic t_refuse();
		rd_chk(12'h800, 32'h00000000, 1'b1);
		rd_chk(12'h429, 32'h00000000, 1'b1);
		rd_chk(12'h460, 32'h00000000, 1'b1);
		$display("test refuse done");
	endtask

	// one completed table read moves the counter by one
	task automatic t_count();
		rd_chk(12'h004, n_tab, 1'b0);
		rd_chk(12'h42C, 32'h00000052, 1'b0);
		rd_chk(12'h004, n_tab, 1'b0);
		$display("test count done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// verdict
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_mux();
		t_table();
		t_write();
		t_refuse();
		t_count();
		complete_run();
	end
endmodule
`default_nettype wire

// ===== rtl/eqt_params.svh
`ifndef EQT_PARAMS_SVH
`define EQT_PARAMS_SVH
// word index of each location; byte address is four times it
`define EQT_IDX_CTRL     10'h000
`define EQT_IDX_STAT     10'h001
`define EQT_IDX_SIG0     10'h10A
`define EQT_IDX_SIG1     10'h10B
`define EQT_IDX_SIG2     10'h10C
`define EQT_IDX_MAJOR    10'h10D
`define EQT_IDX_MINOR    10'h10E
`define EQT_IDX_FEAT0    10'h10F
`define EQT_IDX_FEAT1    10'h110
`define EQT_IDX_FEAT2    10'h111
`define EQT_IDX_FEAT3    10'h112
`define EQT_IDX_SUSP     10'h113
`define EQT_IDX_LOCK0    10'h114
`define EQT_IDX_LOCK1    10'h115
`define EQT_IDX_VCC      10'h116
`define EQT_IDX_VPP      10'h117
// table contents
`define EQT_VAL_SIG0     8'h50
`define EQT_VAL_SIG1     8'h52
`define EQT_VAL_SIG2     8'h49
`define EQT_VAL_MAJOR    8'h31
`define EQT_VAL_MINOR    8'h34
`define EQT_FEAT0_BASE   8'h66
`define EQT_FEAT0_PAGE   8'h80
`define EQT_VAL_FEAT1    8'h07
`define EQT_VAL_FEAT2    8'h00
`define EQT_VAL_FEAT3    8'h00
`define EQT_VAL_SUSP     8'h01
`define EQT_VAL_LOCK0    8'h33
`define EQT_VAL_LOCK1    8'h00
`define EQT_VAL_VCC      8'h18
`define EQT_VAL_VPP      8'h90
// field positions and reset values
`define EQT_CTRL_MUX     0
`define EQT_ALIGN_OK     2'h0
`define EQT_BYTE_ZERO    8'h00
`define EQT_UPPER_ZERO   24'h000000
`define EQT_WORD_ZERO    32'h00000000
`define EQT_CNT_ZERO     16'h0000
`define EQT_CNT_ONE      16'h0001
`endif

// ===== rtl/eqt_pkg.sv
package eqt_pkg;
	typedef logic [11:0] eqt_addr_t;   // apb byte address
	typedef logic [31:0] eqt_word_t;   // apb data word
	typedef logic [9:0]  eqt_idx_t;    // word index
	typedef logic [7:0]  eqt_byte_t;   // one table byte
	typedef logic [15:0] eqt_cnt_t;    // query read counter
endpackage

// ===== rtl/eqt_rom.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "eqt_params.svh"

module eqt_rom
(
	input  wire logic             REF_CLK,
	input  wire logic             RST_N,
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire eqt_pkg::eqt_addr_t PADDR,
	input  wire eqt_pkg::eqt_word_t PWDATA,
	output var  eqt_pkg::eqt_word_t PRDATA,
	output logic                  PREADY,
	output var  logic             PSLVERR
);
	import eqt_pkg::*;

	////////////////////////////////////////////////////////////////
	// table lookup

	// one table byte per index; unlisted index gives zero
	function automatic eqt_byte_t eqt_lookup
	(
		input eqt_idx_t idx,
		input logic     mux
	);
		eqt_byte_t b;
		b = `EQT_BYTE_ZERO;
		case (idx)
			`EQT_IDX_SIG0:  b = `EQT_VAL_SIG0;
			`EQT_IDX_SIG1:  b = `EQT_VAL_SIG1;
			`EQT_IDX_SIG2:  b = `EQT_VAL_SIG2;
			`EQT_IDX_MAJOR: b = `EQT_VAL_MAJOR;
			`EQT_IDX_MINOR: b = `EQT_VAL_MINOR;
			// page read only without the a/d mux bus
			`EQT_IDX_FEAT0: b = mux ? `EQT_FEAT0_BASE
				: (`EQT_FEAT0_BASE | `EQT_FEAT0_PAGE);
			`EQT_IDX_FEAT1: b = `EQT_VAL_FEAT1;
			`EQT_IDX_FEAT2: b = `EQT_VAL_FEAT2;
			// bit 31 and bit 30 stay clear: no extension
			`EQT_IDX_FEAT3: b = `EQT_VAL_FEAT3;
			`EQT_IDX_SUSP:  b = `EQT_VAL_SUSP;
			`EQT_IDX_LOCK0: b = `EQT_VAL_LOCK0;
			`EQT_IDX_LOCK1: b = `EQT_VAL_LOCK1;
			`EQT_IDX_VCC:   b = `EQT_VAL_VCC;
			`EQT_IDX_VPP:   b = `EQT_VAL_VPP;
			default:        b = `EQT_BYTE_ZERO;
		endcase
		return b;
	endfunction

	// true for every table location
	function automatic logic eqt_in_table
	(
		input eqt_idx_t idx
	);
		return (idx >= `EQT_IDX_SIG0) && (idx <= `EQT_IDX_VPP);
	endfunction

	////////////////////////////////////////////////////////////////
	// state

	logic     mux_r;     // a/d mux bus variant select
	logic     mux_nxt;   // next value of the select
	eqt_cnt_t cnt_r;     // completed table reads
	eqt_cnt_t cnt_nxt;   // next counter value
	eqt_word_t rdata_r;  // read word, loaded in setup
	eqt_word_t rdata_nxt;
	logic     err_r;     // error flag for the access
	logic     err_nxt;

	////////////////////////////////////////////////////////////////
	// decode

	eqt_idx_t idx;       // word index of the request
	logic     aligned;   // byte offset within word is zero
	logic     hit_tab;   // table location
	logic     hit_ctrl;  // control register
	logic     hit_stat;  // status register
	logic     mapped;    // any known location
	logic     setup;     // first cycle of a transfer
	logic     access;    // completing cycle of a transfer
	eqt_byte_t tab_byte; // table byte for the index
	eqt_word_t rd_word;  // word a read would return

	assign idx      = PADDR[11:2];
	assign aligned  = (PADDR[1:0] == `EQT_ALIGN_OK);
	assign hit_tab  = aligned && eqt_in_table(idx);
	assign hit_ctrl = aligned && (idx == `EQT_IDX_CTRL);
	assign hit_stat = aligned && (idx == `EQT_IDX_STAT);
	assign mapped   = hit_tab || hit_ctrl || hit_stat;
	assign setup    = PSEL && !PENABLE;
	assign access   = PSEL && PENABLE;
	assign tab_byte = eqt_lookup(idx, mux_r);

	// table byte on the low lane, upper lanes zero
	assign rd_word = hit_tab ? {`EQT_UPPER_ZERO, tab_byte}
		: hit_ctrl ? {31'h00000000, mux_r}
		: hit_stat ? {16'h0000, cnt_r}
		: `EQT_WORD_ZERO;

	// read data is captured in setup so the access phase needs
	// no wait state and the data pins come from flip-flops
	assign rdata_nxt = setup ? (PWRITE ? `EQT_WORD_ZERO : rd_word)
		: rdata_r;

	// only an unmapped or misaligned address is an error; a
	// write to the table is accepted and simply dropped
	assign err_nxt = setup ? !mapped : err_r;

	// only the control register takes writes
	assign mux_nxt = (access && PWRITE && hit_ctrl)
		? PWDATA[`EQT_CTRL_MUX] : mux_r;

	// counter shows how many table reads have completed; it
	// wraps silently, which software must allow for
	assign cnt_nxt = (access && !PWRITE && hit_tab)
		? cnt_r + `EQT_CNT_ONE : cnt_r;

	////////////////////////////////////////////////////////////////
	// registers

	// control and status state
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			mux_r <= 1'b0;
			cnt_r <= `EQT_CNT_ZERO;
		end
		else
		begin
			mux_r <= mux_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// bus answer flip-flops
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rdata_r <= `EQT_WORD_ZERO;
			err_r   <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			err_r   <= err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign PREADY  = 1'b1;  // never waits
	assign PRDATA  = rdata_r;
	assign PSLVERR = err_r && access;

	////////////////////////////////////////////////////////////////
	// checks

	// a read of one word index, setup then access
	sequence s_rd(eqt_idx_t i);
		PSEL && !PENABLE && !PWRITE && (PADDR == {i, 2'h0})
		##1 PSEL && PENABLE;
	endsequence

	// a write of one word index, setup then access
	sequence s_wr(eqt_idx_t i);
		PSEL && !PENABLE && PWRITE && (PADDR == {i, 2'h0})
		##1 PSEL && PENABLE;
	endsequence

	property p_rd(eqt_idx_t i, eqt_byte_t v);
		@(posedge REF_CLK) disable iff (!RST_N)
		s_rd(i) |-> (PRDATA == {24'h000000, v}) && !PSLVERR;
	endproperty

	a_sig_p_byte:
	assert property (p_rd(`EQT_IDX_SIG0, 8'h50))
		else $error("signature byte 0 wrong");
	a_sig_r_byte:
	assert property (p_rd(`EQT_IDX_SIG1, 8'h52))
		else $error("signature byte 1 wrong");
	a_sig_i_byte:
	assert property (p_rd(`EQT_IDX_SIG2, 8'h49))
		else $error("signature byte 2 wrong");
	a_major_ver:
	assert property (p_rd(`EQT_IDX_MAJOR, 8'h31))
		else $error("major version wrong");
	a_minor_ver:
	assert property (p_rd(`EQT_IDX_MINOR, 8'h34))
		else $error("minor version wrong");
	a_feat_two:
	assert property (p_rd(`EQT_IDX_FEAT2, 8'h00))
		else $error("feature byte 2 not zero");
	a_feat_ext:
	assert property (p_rd(`EQT_IDX_FEAT3, 8'h00))
		else $error("feature extension bit set");
	a_feat_one:
	assert property (p_rd(`EQT_IDX_FEAT1, 8'h07))
		else $error("feature byte 1 wrong");
	a_suspend_fn:
	assert property (p_rd(`EQT_IDX_SUSP, 8'h01))
		else $error("suspend byte wrong");
	a_lock_low:
	assert property (p_rd(`EQT_IDX_LOCK0, 8'h33))
		else $error("lock mask low wrong");
	a_lock_high:
	assert property (p_rd(`EQT_IDX_LOCK1, 8'h00))
		else $error("lock mask high wrong");
	a_vcc_code:
	assert property (p_rd(`EQT_IDX_VCC, 8'h18))
		else $error("logic supply code wrong");
	a_vpp_code:
	assert property (p_rd(`EQT_IDX_VPP, 8'h90))
		else $error("program supply code wrong");

	// page-mode bit follows the variant select
	a_feat_zero:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_rd(`EQT_IDX_FEAT0) |->
		PRDATA == (mux_r ? 32'h00000066 : 32'h000000E6))
		else $error("feature byte 0 wrong for variant");

	// top byte of the feature field never announces links
	a_feat_links:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_rd(`EQT_IDX_FEAT3) |-> !PRDATA[6] && !PRDATA[7])
		else $error("link or extension bit set");

	// a write to feature byte 0 changes neither the select nor the counter
	a_write_ignored:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_wr(`EQT_IDX_FEAT0) |=>
		$stable(mux_r) && $stable(cnt_r))
		else $error("table write had an effect");

	// every table read shows zero above the low byte
	a_upper_zero:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		access && !PWRITE && $past(hit_tab && setup)
		|-> PRDATA[31:8] == 24'h000000)
		else $error("upper data lanes not zero");

	// a control write steers the next feature read
	a_ctrl_steer:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_wr(`EQT_IDX_CTRL) |=> mux_r == $past(PWDATA[`EQT_CTRL_MUX]))
		else $error("variant select not written");

	// each completed table read bumps the counter by one
	a_count_step:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		access && !PWRITE && hit_tab |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("read counter did not step");

	// a refused address answers with the error flag and zero data
	a_refuse_err:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		setup && !mapped ##1 access |-> PSLVERR && (PRDATA == `EQT_WORD_ZERO))
		else $error("refused access not flagged");

	// a table write is taken without error, so hosts need no retry
	a_tab_wr_ok:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		setup && PWRITE && hit_tab ##1 access |-> !PSLVERR)
		else $error("table write flagged as error");

	// a write never hands back stale read data
	a_wr_zero:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		setup && PWRITE ##1 access |-> PRDATA == `EQT_WORD_ZERO)
		else $error("write returned data");

	// only table reads move the counter
	a_count_hold:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!(access && !PWRITE && hit_tab) |=> $stable(cnt_r))
		else $error("read counter moved without a table read");

	// the error flag never shows outside an access phase
	a_err_access:
	assert property (@(posedge REF_CLK) disable iff (!RST_N)
		PSLVERR |-> PSEL && PENABLE)
		else $error("error flag outside access");
endmodule
`default_nettype wire
